// ==== core/srl_defs.svh ====
// Constants for the serdes receive and loopback model: widths, counts and pin codes.
// Assumes one 10 MHz clock in which one cycle stands for one serial bit time.
`ifndef SRL_DEFS_SVH
`define SRL_DEFS_SVH

// Parallel word width and the bit counter that walks it.
`define SRL_WORD_W 16
`define SRL_BIT_LAST 4'hf
// Word stages held before the output register, giving about five word periods.
`define SRL_PIPE_DEPTH 4
// Reference periods in bit times for the fast and slow divide settings.
`define SRL_REF_DIV_FAST 8'h10
`define SRL_REF_DIV_SLOW 8'h40
// Bit times without a reference edge after which the reference counts as absent.
`define SRL_REF_ABSENT 8'hc8
// Bit times the lock indicator stays low after an out-of-range measurement.
`define SRL_DROP_LEN 3'h4
// Test-loop select code that picks the parallel diagnostic loop.
`define SRL_DIAG_SEL 2'h2
// Serial drive codes: power-on default and the reduced swing for pluggable modules.
`define SRL_SER_DRIVE_DEFAULT 2'h3
`define SRL_SER_DRIVE_REDUCED 2'h1

`endif

// ==== core/srl_pkg.sv ====
// Types shared by both ends of the serdes receive and loopback model.
// Assumes srl_defs.svh is on the include path.
`include "srl_defs.svh"

package srl_pkg;

  // One parallel word.
  typedef logic [`SRL_WORD_W-1:0] srl_word_t;

  // Lock detector states.
  typedef enum logic [1:0] {SRL_HUNT, SRL_LOCKED, SRL_DROP} srl_lock_e;

  // Whole state of the device end.
  typedef struct packed {
    logic ser_s1;
    logic ser_s2;
    logic rst_s1;
    logic rst_s2;
    logic mref_s1;
    logic mref_s2;
    logic mref_p;
    logic rref_s1;
    logic rref_s2;
    logic rref_p;
    logic txc_s1;
    logic txc_s2;
    logic txc_p;
    srl_word_t txd_s1;
    srl_word_t txd_s2;
    srl_word_t tx_word;
    logic [3:0] bit_cnt;
    srl_word_t rx_shift;
    srl_word_t [`SRL_PIPE_DEPTH-1:0] pipe;
    srl_word_t rx_data;
    logic rx_clk;
    logic rate_clk;
    srl_word_t ser_shift;
    logic ser_out;
    srl_lock_e lk_state;
    logic [7:0] per_cnt;
    logic [7:0] miss_cnt;
    logic [7:0] mmiss_cnt;
    logic [2:0] drop_cnt;
    logic lock;
    logic main_ok;
    logic [1:0] par_drive;
    logic [1:0] ser_drive;
  } srl_dev_s;

  // Whole state of the host end.
  typedef struct packed {
    logic [5:0] ref_cnt;
    logic mref;
    logic rref;
    logic [4:0] txc_cnt;
    logic txc;
    srl_word_t txd;
    logic tx_ready;
    srl_word_t rxd_s1;
    srl_word_t rxd_s2;
    logic rxc_s1;
    logic rxc_s2;
    logic rxc_p;
    logic lk_s1;
    logic lk_s2;
    srl_word_t rx_word;
    logic rx_valid;
  } srl_host_s;

endpackage

// ==== core/srl_link_if.sv ====
// Pins between the serdes device and the framer or host logic.
// Assumes both ends run on the same clk; nothing here is two-way.
`timescale 1ns/1ps

interface srl_link_if;
  import srl_pkg::*;

  // Host to device: reset, references and configuration straps.
  logic receive_reset_n;
  logic main_reference_clock;
  logic receive_reference_clock;
  logic reference_divide_select;
  logic use_receive_reference;
  logic [1:0] lock_window_select;
  logic low_bit_first_n;
  logic [1:0] parallel_drive_strength;
  logic [1:0] serial_drive_strength;
  logic self_test_enable_n;
  logic parallel_loop_enable_n;
  logic [1:0] test_loop_select;
  logic line_loop_enable_n;
  logic rate_clock_out_select;
  // Host to device: parallel transmit bus.
  srl_word_t parallel_tx_data;
  logic parallel_tx_clock_neg;
  logic tx_clock_ratio_select;
  // Device to host: parallel receive bus and status.
  srl_word_t parallel_rx_data;
  logic parallel_rx_clock_out;
  logic receive_lock;
  logic parallel_rate_clock_out;

  // Device end.
  modport dev (
    input receive_reset_n, main_reference_clock, receive_reference_clock,
    input reference_divide_select, use_receive_reference, lock_window_select,
    input low_bit_first_n, parallel_drive_strength, serial_drive_strength,
    input self_test_enable_n, parallel_loop_enable_n, test_loop_select,
    input line_loop_enable_n, rate_clock_out_select,
    input parallel_tx_data, parallel_tx_clock_neg, tx_clock_ratio_select,
    output parallel_rx_data, parallel_rx_clock_out, receive_lock, parallel_rate_clock_out
  );

  // Host end.
  modport host (
    output receive_reset_n, main_reference_clock, receive_reference_clock,
    output reference_divide_select, use_receive_reference, lock_window_select,
    output low_bit_first_n, parallel_drive_strength, serial_drive_strength,
    output self_test_enable_n, parallel_loop_enable_n, test_loop_select,
    output line_loop_enable_n, rate_clock_out_select,
    output parallel_tx_data, parallel_tx_clock_neg, tx_clock_ratio_select,
    input parallel_rx_data, parallel_rx_clock_out, receive_lock, parallel_rate_clock_out
  );
endinterface

// ==== core/srl_device.sv ====
// Device end: lock detector, 1:16 deserializer, parallel receive bus and loopbacks.
// Assumes clk stands for the recovered bit clock, one serial bit per cycle, and that
// the host end drives the link pins; reference and transmit clocks are sampled levels.
//
// Summary of operation
// R1: Lock high while selected reference in range.
// R2: Lock low in receive reset or absent reference.
// R3: Out-of-range drops lock briefly, then relocks.
// R4: Sixteen serial bits form one parallel word.
// R5: First bit to bit 15 when select high.
// R6: Receive word driven with its own clock.
// R7: About five word periods serial to parallel.
// R8: Two-bit parallel output drive strength input.
// R9: Host picks serial drive 01 for modules.
// R10: Diagnostic code loops transmit words to receive.
// R11: Line loop sends received words out serially.
// R12: Host routes receive clock to main reference.
// R13: Host cleans rate clock externally for reference; the host here uses it uncleaned.
// R14: Recovery uses either reference, transmit only main.
// R15: One divide select sets both references together.
// R16: Host drives receive reference only when needed.
// R17: Transmit bus taken on negative leg rise.
// R18: Receive clock keeps running without serial data.
// R19: Transmit bit order follows the same select.
// R20: Ratio select picks one or two words per period.
// R21: Exactly one new word per receive clock period.
`timescale 1ns/1ps
`include "srl_defs.svh"

module srl_device (
  // Clock and reset.
  input wire logic clk,
  input wire logic resetn,
  // Link to the host end.
  srl_link_if.dev link,
  // Serial line side.
  input wire logic serial_rx_in,
  output logic serial_tx_out,
  // Drive settings as applied to the output stages, and transmit reference status.
  output logic [1:0] parallel_drive_level,
  output logic [1:0] serial_drive_level,
  output logic tx_reference_ok
);
  import srl_pkg::*;

  // Present and next state of the whole end.
  srl_dev_s q;
  srl_dev_s d;

  // Combinational helpers.
  logic ref_now;
  logic ref_prev;
  logic ref_edge;
  logic [7:0] ref_miss;
  logic [7:0] expect_per;
  logic [7:0] tol;
  logic in_range;
  logic word_end;
  logic diag_loop;
  logic txc_rise;
  logic txc_fall;

  // Next-state logic for every part of the end.
  always_comb begin
    d = q;
    // Two flip-flops on the serial, reset, reference and transmit levels from outside the bit clock; the straps are used directly.
    d.ser_s1 = serial_rx_in;
    d.ser_s2 = q.ser_s1;
    d.rst_s1 = link.receive_reset_n;
    d.rst_s2 = q.rst_s1;
    d.mref_s1 = link.main_reference_clock;
    d.mref_s2 = q.mref_s1;
    d.mref_p = q.mref_s2;
    d.rref_s1 = link.receive_reference_clock;
    d.rref_s2 = q.rref_s1;
    d.rref_p = q.rref_s2;
    d.txc_s1 = link.parallel_tx_clock_neg;
    d.txc_s2 = q.txc_s1;
    d.txc_p = q.txc_s2;
    d.txd_s1 = link.parallel_tx_data;
    d.txd_s2 = q.txd_s1;

    // R14: recovery reference choice
    ref_now = link.use_receive_reference ? q.rref_s2 : q.mref_s2;
    ref_prev = link.use_receive_reference ? q.rref_p : q.mref_p;
    ref_edge = ref_now & ~ref_prev;
    // R15: one divide for both
    expect_per = link.reference_divide_select ? `SRL_REF_DIV_SLOW : `SRL_REF_DIV_FAST;
    // The window select widens the accepted period: 1, 2, 4 or 8 bit times.
    tol = 8'h01 << link.lock_window_select;
    in_range = (q.per_cnt + tol >= expect_per) && (q.per_cnt <= expect_per + tol);

    // Period and absence counters of the recovery reference.
    d.per_cnt = ref_edge ? 8'h01 : q.per_cnt + ((q.per_cnt == 8'hff) ? 8'h00 : 8'h01);
    ref_miss = ref_edge ? 8'h00 : q.miss_cnt + ((q.miss_cnt == 8'hff) ? 8'h00 : 8'h01);
    d.miss_cnt = ref_miss;
    // R14: transmit side watches main only
    d.mmiss_cnt = (q.mref_s2 & ~q.mref_p) ? 8'h00 :
                  q.mmiss_cnt + ((q.mmiss_cnt == 8'hff) ? 8'h00 : 8'h01);
    d.main_ok = q.mmiss_cnt < `SRL_REF_ABSENT;

    // Lock detector.
    case (q.lk_state)
      SRL_HUNT: begin
        // R1: lock on good period
        if (ref_edge && in_range) begin
          d.lk_state = SRL_LOCKED;
        end
      end
      SRL_LOCKED: begin
        // R3: drop on bad period
        if (ref_edge && !in_range) begin
          d.lk_state = SRL_DROP;
          d.drop_cnt = `SRL_DROP_LEN;
        end
      end
      SRL_DROP: begin
        // R3: relock after brief drop
        if (q.drop_cnt == 3'h1) begin
          d.lk_state = SRL_LOCKED;
        end
        d.drop_cnt = q.drop_cnt - 3'h1;
      end
      default: begin
        d.lk_state = SRL_HUNT;
      end
    endcase
    // R2: reset or absent reference
    if (!q.rst_s2 || ref_miss >= `SRL_REF_ABSENT) begin
      d.lk_state = SRL_HUNT;
    end
    d.lock = (d.lk_state == SRL_LOCKED);

    // R18: word divider runs free of data
    d.bit_cnt = q.bit_cnt + 4'h1;
    word_end = (q.bit_cnt == `SRL_BIT_LAST);

    // R4: shift serial bits in
    // R5: order set by select
    if (link.low_bit_first_n) begin
      d.rx_shift = {q.rx_shift[`SRL_WORD_W-2:0], q.ser_s2};
    end else begin
      d.rx_shift = {q.ser_s2, q.rx_shift[`SRL_WORD_W-1:1]};
    end

    // R17: capture on negative leg rise
    txc_rise = q.txc_s2 & ~q.txc_p;
    txc_fall = ~q.txc_s2 & q.txc_p;
    if (txc_rise) begin
      d.tx_word = q.txd_s2;
    end else if (txc_fall && !link.tx_clock_ratio_select) begin
      // R20: half-rate clock, second word
      d.tx_word = q.txd_s2;
    end

    // R10: diagnostic loop select
    diag_loop = !link.self_test_enable_n && !link.parallel_loop_enable_n &&
                (link.test_loop_select == `SRL_DIAG_SEL);

    if (word_end) begin
      // R21: one word per period
      // R7: word delay line
      d.pipe[0] = diag_loop ? q.tx_word : d.rx_shift;
      for (int i = 1; i < `SRL_PIPE_DEPTH; i++) begin
        d.pipe[i] = q.pipe[i-1];
      end
      // R6: data changes with clock rise
      d.rx_data = q.pipe[`SRL_PIPE_DEPTH-1];
      // R11: line loop feeds serializer
      d.ser_shift = link.line_loop_enable_n ? q.tx_word : d.rx_shift;
    end else if (link.low_bit_first_n) begin
      // R19: bit 15 first when high
      d.ser_shift = {q.ser_shift[`SRL_WORD_W-2:0], 1'b0};
    end else begin
      d.ser_shift = {1'b0, q.ser_shift[`SRL_WORD_W-1:1]};
    end
    // R19: serial output bit
    d.ser_out = link.low_bit_first_n ? d.ser_shift[`SRL_WORD_W-1] : d.ser_shift[0];

    // R6: receive clock high for first half
    d.rx_clk = (d.bit_cnt < 4'h8);
    // The rate clock output follows the word clock only while selected.
    d.rate_clk = link.rate_clock_out_select & d.rx_clk;

    // R8: drive strength applied
    d.par_drive = link.parallel_drive_strength;
    // R9: host-chosen serial drive
    d.ser_drive = link.serial_drive_strength;
  end

  // State register with constant reset values.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      q <= '0;
      q.lk_state <= SRL_HUNT;
      // Starting on the last bit makes the first receive clock period a full one.
      q.bit_cnt <= `SRL_BIT_LAST;
      q.ser_drive <= `SRL_SER_DRIVE_DEFAULT;
    end else begin
      q <= d;
    end
  end

  // Outputs are taken straight from the state register.
  assign link.parallel_rx_data = q.rx_data;
  assign link.parallel_rx_clock_out = q.rx_clk;
  assign link.receive_lock = q.lock;
  assign link.parallel_rate_clock_out = q.rate_clk;
  assign serial_tx_out = q.ser_out;
  assign parallel_drive_level = q.par_drive;
  assign serial_drive_level = q.ser_drive;
  assign tx_reference_ok = q.main_ok;
endmodule

// ==== core/srl_host.sv ====
// Host end: drives references, straps and the transmit bus, and takes receive words.
// Assumes the device end on the same clk; receive data, clock and lock are still resynchronised.
`timescale 1ns/1ps
`include "srl_defs.svh"

module srl_host (
  // Clock and reset.
  input wire logic clk,
  input wire logic resetn,
  // Link to the device end.
  srl_link_if.host link,
  // Configuration from the user.
  input wire logic cfg_rx_reset_n,
  input wire logic cfg_main_ref_on,
  input wire logic cfg_rx_ref_on,
  input wire logic cfg_ref_div_sel,
  input wire logic cfg_use_rx_ref,
  input wire logic [1:0] cfg_lock_window,
  input wire logic cfg_low_bit_first_n,
  input wire logic [1:0] cfg_parallel_drive,
  input wire logic cfg_reduced_swing,
  input wire logic cfg_self_test_en_n,
  input wire logic cfg_parallel_loop_en_n,
  input wire logic [1:0] cfg_test_loop_sel,
  input wire logic cfg_line_loop_en_n,
  input wire logic cfg_rate_clock_out_sel,
  input wire logic cfg_tx_ratio_sel,
  // Transmit words from the user.
  input wire srl_pkg::srl_word_t tx_word,
  input wire logic tx_valid,
  output logic tx_ready,
  // Receive words to the user.
  output srl_pkg::srl_word_t rx_word,
  output logic rx_valid,
  output logic rx_locked
);
  import srl_pkg::*;

  // Present and next state.
  srl_host_s q;
  srl_host_s d;
  logic change;
  logic div_ref; // Divided reference before it is gated.

  // Next-state logic.
  always_comb begin
    d = q;
    // R15: both references share one divider
    d.ref_cnt = q.ref_cnt + 6'h1;
    div_ref = cfg_ref_div_sel ? d.ref_cnt[5] : d.ref_cnt[3];
    // R12: line loop uses receive clock
    // R13: rate clock stands in directly, not cleaned
    d.mref = cfg_main_ref_on & (cfg_line_loop_en_n ? div_ref : cfg_rate_clock_out_sel ?
             link.parallel_rate_clock_out : link.parallel_rx_clock_out);
    // R16: receive reference only when enabled
    d.rref = cfg_rx_ref_on & div_ref;
    // R20: transmit clock at 1/16 or 1/32
    d.txc_cnt = q.txc_cnt + 5'h1;
    d.txc = cfg_tx_ratio_sel ? d.txc_cnt[3] : d.txc_cnt[4];
    // Data changes half a word away from the sampling edges.
    change = (d.txc_cnt[3:0] == (cfg_tx_ratio_sel ? 4'h0 : 4'h8));
    d.tx_ready = change;
    if (change) begin
      d.txd = tx_valid ? tx_word : '0;
    end
    // Receive data, receive clock and lock pass two flip-flops; the rate clock is used directly.
    d.rxd_s1 = link.parallel_rx_data;
    d.rxd_s2 = q.rxd_s1;
    d.rxc_s1 = link.parallel_rx_clock_out;
    d.rxc_s2 = q.rxc_s1;
    d.rxc_p = q.rxc_s2;
    d.lk_s1 = link.receive_lock;
    d.lk_s2 = q.lk_s1;
    // Receive word taken on the rising edge of the receive clock.
    d.rx_valid = q.rxc_s2 & ~q.rxc_p;
    if (d.rx_valid) begin
      d.rx_word = q.rxd_s2;
    end
  end

  // State register.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // Strap and clock pins.
  assign link.receive_reset_n = cfg_rx_reset_n;
  assign link.main_reference_clock = q.mref;
  assign link.receive_reference_clock = q.rref;
  assign link.reference_divide_select = cfg_ref_div_sel;
  assign link.use_receive_reference = cfg_use_rx_ref;
  assign link.lock_window_select = cfg_lock_window;
  assign link.low_bit_first_n = cfg_low_bit_first_n;
  assign link.parallel_drive_strength = cfg_parallel_drive;
  // R9: reduced swing for modules
  assign link.serial_drive_strength = cfg_reduced_swing ? `SRL_SER_DRIVE_REDUCED :
                                                          `SRL_SER_DRIVE_DEFAULT;
  assign link.self_test_enable_n = cfg_self_test_en_n;
  assign link.parallel_loop_enable_n = cfg_parallel_loop_en_n;
  assign link.test_loop_select = cfg_test_loop_sel;
  assign link.line_loop_enable_n = cfg_line_loop_en_n;
  assign link.rate_clock_out_select = cfg_rate_clock_out_sel;
  assign link.tx_clock_ratio_select = cfg_tx_ratio_sel;
  assign link.parallel_tx_data = q.txd;
  assign link.parallel_tx_clock_neg = q.txc;
  // User outputs.
  assign tx_ready = q.tx_ready;
  assign rx_word = q.rx_word;
  assign rx_valid = q.rx_valid;
  assign rx_locked = q.lk_s2;
endmodule

// ==== sim/srl_link_properties.sv ====
// Checker for the link between the serdes device end and the host end.
// Assumes one clock, active-low reset, and an instance beside the link interface.
`timescale 1ns/1ps

module srl_link_properties (
  // Clock and reset.
  input wire logic clk,
  input wire logic resetn,
  // Host to device pins.
  input wire logic receive_reset_n,
  input wire logic main_reference_clock,
  input wire logic receive_reference_clock,
  input wire logic use_receive_reference,
  input wire logic [1:0] serial_drive_strength,
  input wire logic self_test_enable_n,
  input wire logic parallel_loop_enable_n,
  input wire logic [1:0] test_loop_select,
  input wire logic rate_clock_out_select,
  input wire srl_pkg::srl_word_t parallel_tx_data,
  input wire logic parallel_tx_clock_neg,
  input wire logic tx_clock_ratio_select,
  // Device to host pins.
  input wire srl_pkg::srl_word_t parallel_rx_data,
  input wire logic parallel_rx_clock_out,
  input wire logic receive_lock,
  input wire logic parallel_rate_clock_out
);
  import srl_pkg::*;
  localparam int IdleLim = 220; // Quiet cycles after which lock must be gone.
  localparam int DiagLim = 180; // Steady loop cycles after which the word must be back.
  logic sel_ref; // Reference the recovery loop listens to.
  logic sel_ref_q;
  logic use_q;
  logic [8:0] idle_q; // Cycles since the selected reference moved.
  logic diag; // Diagnostic loop code is set.
  srl_word_t txd_q;
  logic [7:0] diag_q; // Cycles in the loop with steady transmit data.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  assign sel_ref = use_receive_reference ? receive_reference_clock : main_reference_clock;
  assign diag = !self_test_enable_n && !parallel_loop_enable_n && test_loop_select == 2'h2;
  // Counts quiet reference time and steady loop time, both saturating.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sel_ref_q <= 1'b0;
      use_q <= 1'b0;
      idle_q <= 9'h0;
      txd_q <= 16'h0;
      diag_q <= 8'h0;
    end else begin
      sel_ref_q <= sel_ref;
      use_q <= use_receive_reference;
      txd_q <= parallel_tx_data;
      if (sel_ref != sel_ref_q || use_receive_reference != use_q) begin
        idle_q <= 9'h0;
      end else if (idle_q != 9'h1ff) begin
        idle_q <= idle_q + 9'h1;
      end
      if (!diag || parallel_tx_data != txd_q) begin
        diag_q <= 8'h0;
      end else if (diag_q != 8'hff) begin
        diag_q <= diag_q + 8'h1;
      end
    end
  end

  AST_LOCK_RESET: assert property (
    !receive_reset_n [*4] |-> !receive_lock) else $error("lock high in receive reset");
  AST_LOCK_ABSENT: assert property (
    idle_q > IdleLim |-> !receive_lock) else $error("lock high without reference");
  AST_RX_CLK_SHAPE: assert property (
    $rose(parallel_rx_clock_out) |=> parallel_rx_clock_out [*7] ##1 !parallel_rx_clock_out [*8]
    ##1 parallel_rx_clock_out) else $error("receive clock period wrong");
  AST_RX_DATA_SYNC: assert property (
    $changed(parallel_rx_data) |-> $rose(parallel_rx_clock_out)) else $error("data off clock");
  AST_RATE_OFF: assert property (
    !rate_clock_out_select [*2] |-> !parallel_rate_clock_out) else $error("rate clock on");
  AST_RATE_FOLLOW: assert property (
    rate_clock_out_select [*2] |-> parallel_rate_clock_out == parallel_rx_clock_out)
    else $error("rate clock differs");
  AST_DIAG_LOOP: assert property (
    diag_q > DiagLim |-> parallel_rx_data == parallel_tx_data) else $error("loop word lost");
  AST_TXCLK_FAST: assert property (
    $rose(parallel_tx_clock_neg) && tx_clock_ratio_select |=> parallel_tx_clock_neg [*7]
    ##1 !parallel_tx_clock_neg [*8] ##1 parallel_tx_clock_neg) else $error("fast clock wrong");
  AST_TXCLK_SLOW: assert property (
    $rose(parallel_tx_clock_neg) && !tx_clock_ratio_select |-> ##16 !parallel_tx_clock_neg
    ##16 parallel_tx_clock_neg) else $error("slow clock wrong");
  AST_SER_DRIVE: assert property (
    serial_drive_strength inside {2'h1, 2'h3}) else $error("serial drive code wrong");

  // Main scenarios reached.
  COV_LOCK: cover property ($rose(receive_lock));
  COV_DIAG: cover property (diag_q > DiagLim);
  COV_RX_RESET: cover property ($fell(receive_lock) && !receive_reset_n);
  COV_SLOW: cover property ($rose(parallel_tx_clock_neg) && !tx_clock_ratio_select);
endmodule

// ==== sim/serdes_receive_loopback_tb_top.sv ====
// Bench joining the device and host ends through the link interface.
// Assumes the design files under core/ are compiled first.
`timescale 1ns/1ps

module serdes_receive_loopback_tb_top;
  import srl_pkg::*;
  localparam int Dly = 10; // Input change delay after each rising edge.
  localparam int Ceiling = 8000; // Cycle limit for the whole run.
  localparam srl_word_t RxPat = 16'h0035; // Serial pattern, no rotation of its reverse.
  localparam srl_word_t TxPat = 16'h0013; // Transmit word, distinct from the pattern.
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic cfg_rx_reset_n, cfg_main_ref_on, cfg_rx_ref_on, cfg_ref_div_sel, cfg_use_rx_ref;
  logic [1:0] cfg_lock_window, cfg_parallel_drive, cfg_test_loop_sel;
  logic cfg_low_bit_first_n, cfg_reduced_swing, cfg_self_test_en_n, cfg_parallel_loop_en_n;
  logic cfg_line_loop_en_n, cfg_rate_clock_out_sel, cfg_tx_ratio_sel, tx_valid, tx_ready;
  logic rx_valid, rx_locked, serial_tx_out, tx_reference_ok, pat_on, lock;
  logic serial_rx_in = 1'b0; // Serial bit into the device end.
  logic [1:0] parallel_drive_level, serial_drive_level;
  logic [3:0] pos = 4'h0; // Bit position inside the serial pattern.
  srl_word_t tx_word, rx_word, rx_data, got, w1;
  int fails = 0;
  int checked = 0;
  int cycles = 0;
  int n;

  srl_link_if i_srl_link_if ();
  assign rx_data = i_srl_link_if.parallel_rx_data;
  assign lock = i_srl_link_if.receive_lock;
  srl_device i_srl_device (.clk, .resetn, .link(i_srl_link_if.dev), .serial_rx_in,
    .serial_tx_out, .parallel_drive_level, .serial_drive_level, .tx_reference_ok);
  srl_host i_srl_host (.clk, .resetn, .link(i_srl_link_if.host), .cfg_rx_reset_n,
    .cfg_main_ref_on, .cfg_rx_ref_on, .cfg_ref_div_sel, .cfg_use_rx_ref, .cfg_lock_window,
    .cfg_low_bit_first_n, .cfg_parallel_drive, .cfg_reduced_swing, .cfg_self_test_en_n,
    .cfg_parallel_loop_en_n, .cfg_test_loop_sel, .cfg_line_loop_en_n, .cfg_rate_clock_out_sel,
    .cfg_tx_ratio_sel, .tx_word, .tx_valid, .tx_ready, .rx_word, .rx_valid, .rx_locked);
  srl_link_properties i_srl_link_properties (.clk, .resetn,
    .receive_reset_n(i_srl_link_if.receive_reset_n),
    .main_reference_clock(i_srl_link_if.main_reference_clock),
    .receive_reference_clock(i_srl_link_if.receive_reference_clock),
    .use_receive_reference(i_srl_link_if.use_receive_reference),
    .serial_drive_strength(i_srl_link_if.serial_drive_strength),
    .self_test_enable_n(i_srl_link_if.self_test_enable_n),
    .parallel_loop_enable_n(i_srl_link_if.parallel_loop_enable_n),
    .test_loop_select(i_srl_link_if.test_loop_select),
    .rate_clock_out_select(i_srl_link_if.rate_clock_out_select),
    .parallel_tx_data(i_srl_link_if.parallel_tx_data),
    .parallel_tx_clock_neg(i_srl_link_if.parallel_tx_clock_neg),
    .tx_clock_ratio_select(i_srl_link_if.tx_clock_ratio_select),
    .parallel_rx_data(rx_data), .parallel_rx_clock_out(i_srl_link_if.parallel_rx_clock_out),
    .receive_lock(lock), .parallel_rate_clock_out(i_srl_link_if.parallel_rate_clock_out));

  // Free-running clock of 100 ns.
  always #50 clk = ~clk;

  // Sends the serial pattern first bit high, or zeros when the pattern is off.
  always @(posedge clk) begin
    #Dly;
    serial_rx_in = pat_on && rx_pat_bit(pos);
    pos = pos + 4'h1;
  end

  // Cuts a hang short.
  always @(posedge clk) begin
    cycles++;
    if (cycles == Ceiling) begin
      fails++;
      $display("wrong value at %0t: run too long", $time);
      give_verdict();
    end
  end

  function automatic logic rx_pat_bit(input logic [3:0] p);
    rx_pat_bit = RxPat[4'hf - p];
  endfunction

  function automatic srl_word_t rev16(input srl_word_t v);
    for (int i = 0; i < 16; i++) rev16[i] = v[15 - i];
  endfunction

  // True when a is some rotation of b.
  function automatic logic is_rot(input srl_word_t a, input srl_word_t b);
    logic [31:0] bb;
    bb = {b, b};
    is_rot = 1'b0;
    for (int r = 0; r < 16; r++) if (bb[r +: 16] === a) is_rot = 1'b1;
  endfunction

  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #Dly;
  endtask

  task automatic check(input srl_word_t seen, input srl_word_t exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Collects sixteen serial output bits, earliest in bit 15.
  task automatic grab(output srl_word_t w);
    repeat (16) begin
      tick(1);
      w = {w[14:0], serial_tx_out};
    end
  endtask

  task automatic give_verdict;
    $display("comparisons %0d, mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Main sequence.
  initial begin
    {cfg_rx_reset_n, cfg_main_ref_on, cfg_rx_ref_on, cfg_low_bit_first_n} = 4'hf;
    {cfg_self_test_en_n, cfg_parallel_loop_en_n, cfg_line_loop_en_n, cfg_tx_ratio_sel} = 4'hf;
    {cfg_ref_div_sel, cfg_use_rx_ref, cfg_reduced_swing, cfg_rate_clock_out_sel} = 4'h0;
    {cfg_lock_window, cfg_parallel_drive, cfg_test_loop_sel} = 6'h0;
    tx_word = TxPat;
    tx_valid = 1'b1;
    pat_on = 1'b1;
    tick(2);
    check(16'(serial_drive_level), 16'h3);
    check(16'(lock), 16'h0);
    resetn = 1'b1;
    tick(300);
    check(16'(rx_locked), 16'h1);
    check(16'(tx_reference_ok), 16'h1);
    for (n = 0; n < 4; n++) begin
      cfg_parallel_drive = 2'(n);
      cfg_lock_window = 2'(n);
      cfg_rate_clock_out_sel = n[0];
      tick(40);
      check(16'(parallel_drive_level), 16'(n));
      check(16'(lock), 16'h1);
    end
    cfg_reduced_swing = 1'b1;
    tick(3);
    check(16'(serial_drive_level), 16'h1);
    tick(100);
    w1 = rx_data;
    check(16'(is_rot(w1, RxPat)), 16'h1);
    cfg_low_bit_first_n = 1'b0;
    tick(100);
    check(rx_data, rev16(w1));
    grab(got);
    check(16'(is_rot(got, rev16(TxPat))), 16'h1);
    cfg_low_bit_first_n = 1'b1;
    tick(40);
    grab(got);
    check(16'(is_rot(got, TxPat)), 16'h1);
    cfg_line_loop_en_n = 1'b0;
    tick(100);
    grab(got);
    check(16'(is_rot(got, RxPat)), 16'h1);
    // The run of zeros must reach the outputs after about five word periods.
    pat_on = 1'b0;
    n = 0;
    while (rx_data !== 16'h0 && n < 200) begin
      tick(1);
      n++;
    end
    check(16'(n >= 60 && n <= 110), 16'h1);
    cfg_line_loop_en_n = 1'b1;
    cfg_self_test_en_n = 1'b0;
    cfg_parallel_loop_en_n = 1'b0;
    for (n = 0; n < 4; n++) begin
      cfg_test_loop_sel = 2'(n);
      tick(200);
      check(rx_data, (n == 2) ? TxPat : 16'h0);
    end
    cfg_test_loop_sel = 2'h2;
    tick(200);
    // Waits for the receive strobe; a missing one runs into the cycle limit.
    while (rx_valid !== 1'b1) begin
      tick(1);
    end
    check(rx_word, TxPat);
    // The slower transmit clock is only changed across a reset.
    cfg_tx_ratio_sel = 1'b0;
    tx_word = 16'h1234;
    resetn = 1'b0;
    tick(2);
    resetn = 1'b1;
    tick(250);
    check(rx_data, 16'h1234);
    check(rx_word, 16'h1234);
    cfg_rx_reset_n = 1'b0;
    tick(10);
    check(16'(lock), 16'h0);
    cfg_rx_reset_n = 1'b1;
    tick(300);
    check(16'(lock), 16'h1);
    cfg_main_ref_on = 1'b0;
    tick(260);
    check(16'(lock), 16'h0);
    check(16'(tx_reference_ok), 16'h0);
    cfg_use_rx_ref = 1'b1;
    tick(300);
    check(16'(lock), 16'h1);
    check(16'(tx_reference_ok), 16'h0);
    cfg_main_ref_on = 1'b1;
    cfg_ref_div_sel = 1'b1;
    // The divide change leaves one period out of range: lock drops briefly, then returns.
    n = 0;
    while (lock === 1'b1 && n < 100) begin
      tick(1);
      n++;
    end
    check(16'(n < 100), 16'h1);
    tick(8);
    check(16'(lock), 16'h1);
    tick(500);
    check(16'(lock), 16'h1);
    check(16'(tx_reference_ok), 16'h1);
    give_verdict();
  end
endmodule
